/* File: rspi_map.vh */
// Command codes, field positions and limits of the radio serial command port
`ifndef RSPI_MAP_VH
`define RSPI_MAP_VH

// ==========================================================
// Command byte decode
`define RSPI_CMD_PFX_MSB      7
`define RSPI_CMD_PFX_LSB      5
`define RSPI_CMD_RD_PFX       3'h0
`define RSPI_CMD_WR_PFX       3'h1
`define RSPI_CMD_ADDR_MSB     4
`define RSPI_CMD_TXP          8'ha0
`define RSPI_CMD_NO_OPERATION 8'hff

// ==========================================================
// Transfer limits in data bytes
`define RSPI_REG_MAX_BYTES    5
`define RSPI_TXP_MAX_BYTES    32

// ==========================================================
// Status byte layout: pipe number field
`define RSPI_STAT_PIPE_MSB    3
`define RSPI_STAT_PIPE_LSB    1

// ==========================================================
// Reset values
`define RSPI_STATE_RST        3'h0
`define RSPI_BIT_RST          3'h0
`define RSPI_IDX_RST          6'h00
`define RSPI_PIPE_RST         3'h7
`define RSPI_SYNC_RST         1'b0
`define RSPI_CSN_SYNC_RST     1'b1

`endif

/* File: rspi_sync.v */
// Two-flop synchroniser for pin inputs of the serial command port
`timescale 1ns/1ps

module rspi_sync #(
  parameter       RST_VAL = 1'b0
) (
  input  wire     i_clk,
  input  wire     i_arst_n,
  input  wire     i_async,
  output wire     o_sync
);

  reg meta_q;
  reg sync_q;

  // ==========================================================
  // Synchroniser chain
  // First stage feeds only the second stage
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

/* File: rspi_port.v */
// Device-side serial command port: command decode, register and payload transfer
`timescale 1ns/1ps
`include "rspi_map.vh"

module rspi_port #(
  parameter             REG_MAX = `RSPI_REG_MAX_BYTES,
  parameter             TXP_MAX = `RSPI_TXP_MAX_BYTES
) (
  input  wire           I_REF_CLK,
  input  wire           I_ARST_N,
  // Serial pins
  input  wire           I_SCK,
  input  wire           I_CSN_N,
  input  wire           I_MOSI,
  output wire           O_MISO,
  output wire           O_MISO_OE,
  // Status from the radio core
  input  wire [7:0]     I_STATUS,
  input  wire [2:0]     I_PIPE_NUM,
  input  wire           I_IRQ_FALL,
  // Register map access
  output wire [4:0]     O_REG_ADDR,
  output wire [2:0]     O_REG_IDX,
  output wire           O_REG_WE,
  output wire [7:0]     O_REG_WDATA,
  output wire           O_REG_RD,
  input  wire [7:0]     I_REG_RDATA,
  // Transmit payload store
  output wire           O_TXP_WE,
  output wire [4:0]     O_TXP_IDX,
  output wire [7:0]     O_TXP_DATA
);

  // ==========================================================
  // Transfer phases
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD  = 3'h1;
  localparam [2:0] ST_RD   = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_TXP  = 3'h4;
  localparam [2:0] ST_DROP = 3'h5;

  localparam [5:0] REG_LIM = REG_MAX[5:0];
  localparam [5:0] TXP_LIM = TXP_MAX[5:0];

  wire       sck_s;
  wire       csn_s;
  wire       mosi_s;

  reg        sck_prev_q;
  reg        csn_prev_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [2:0] bit_q;
  reg  [6:0] rx_q;
  reg  [5:0] idx_q;
  reg  [5:0] idx_d;
  reg  [7:0] sh_q;
  reg        miso_q;
  reg        oe_q;
  reg  [2:0] pipe_q;
  reg  [4:0] addr_q;
  reg  [4:0] addr_d;
  reg        reg_we_q;
  reg        reg_we_d;
  reg  [7:0] wdata_q;
  reg        reg_rd_q;
  reg        txp_we_q;
  reg        txp_we_d;
  reg  [4:0] txp_idx_q;
  reg  [2:0] reg_idx_q;

  wire       sck_rise = sck_s & ~sck_prev_q;
  wire       sck_fall = ~sck_s & sck_prev_q;
  wire       sel_fall = ~csn_s & csn_prev_q;
  wire       sel_on   = ~csn_s;
  wire       byte_end = sck_rise & (bit_q == 3'h7);
  wire [7:0] rx_byte  = {rx_q, mosi_s};
  wire [7:0] status_b;

  // ==========================================================
  // Pin synchronisers; select idles high
  rspi_sync #(.RST_VAL(`RSPI_SYNC_RST)) u_sync_sck (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  (I_SCK),
    .o_sync   (sck_s)
  );

  rspi_sync #(.RST_VAL(`RSPI_CSN_SYNC_RST)) u_sync_csn (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  (I_CSN_N),
    .o_sync   (csn_s)
  );

  rspi_sync #(.RST_VAL(`RSPI_SYNC_RST)) u_sync_mosi (
    .i_clk    (I_REF_CLK),
    .i_arst_n (I_ARST_N),
    .i_async  (I_MOSI),
    .o_sync   (mosi_s)
  );

  // ==========================================================
  // Status byte with held pipe field
  // Pipe field only moves on the interrupt fall, so a status load in that cycle still carries the previous pipe number
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pipe_q <= `RSPI_PIPE_RST;
    end else if (I_IRQ_FALL) begin
      pipe_q <= I_PIPE_NUM;
    end
  end

  assign status_b = {I_STATUS[7:`RSPI_STAT_PIPE_MSB+1], pipe_q,
                     I_STATUS[`RSPI_STAT_PIPE_LSB-1:0]};

  // ==========================================================
  // Edge history of synchronised pins
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sck_prev_q <= `RSPI_SYNC_RST;
      csn_prev_q <= `RSPI_CSN_SYNC_RST;
    end else begin
      sck_prev_q <= sck_s;
      csn_prev_q <= csn_s;
    end
  end

  // ==========================================================
  // Command decode and per-byte actions
  always @* begin
    state_d  = state_q;
    idx_d    = idx_q;
    addr_d   = addr_q;
    reg_we_d = 1'b0;
    txp_we_d = 1'b0;
    if (byte_end) begin
      case (state_q)
        ST_CMD: begin
          idx_d  = `RSPI_IDX_RST;
          addr_d = rx_byte[`RSPI_CMD_ADDR_MSB:0];
          if (rx_byte[`RSPI_CMD_PFX_MSB:`RSPI_CMD_PFX_LSB] == `RSPI_CMD_RD_PFX) begin
            state_d = ST_RD;
          end else if (rx_byte[`RSPI_CMD_PFX_MSB:`RSPI_CMD_PFX_LSB] == `RSPI_CMD_WR_PFX) begin
            state_d = ST_WR;
          end else if (rx_byte == `RSPI_CMD_TXP) begin
            state_d = ST_TXP;
          end else begin
            // All-ones and unsupported codes carry no data
            state_d = ST_DROP;
          end
        end
        ST_WR: begin
          // Each byte lands on its own, so a short write leaves upper bytes alone
          if (idx_q < REG_LIM) begin
            reg_we_d = 1'b1;
            idx_d    = idx_q + 6'h01;
          end
        end
        ST_RD: begin
          if (idx_q < REG_LIM) begin
            idx_d = idx_q + 6'h01;
          end
        end
        ST_TXP: begin
          if (idx_q < TXP_LIM) begin
            txp_we_d = 1'b1;
            idx_d    = idx_q + 6'h01;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // ==========================================================
  // Receive shifter, phase and counters
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= `RSPI_STATE_RST;
      bit_q   <= `RSPI_BIT_RST;
      rx_q    <= 7'h00;
      idx_q   <= `RSPI_IDX_RST;
      addr_q  <= 5'h00;
    end else if (!sel_on) begin
      state_q <= ST_IDLE;
      bit_q   <= `RSPI_BIT_RST;
      idx_q   <= `RSPI_IDX_RST;
    end else if (sel_fall) begin
      // First byte of every frame is the command
      state_q <= ST_CMD;
      bit_q   <= `RSPI_BIT_RST;
      idx_q   <= `RSPI_IDX_RST;
    end else begin
      if (sck_rise) begin
        rx_q  <= rx_byte[6:0];
        bit_q <= bit_q + 3'h1;
      end
      state_q <= state_d;
      idx_q   <= idx_d;
      addr_q  <= addr_d;
    end
  end

  // ==========================================================
  // Strobes toward register map and payload store
  // Index and data are captured with the strobe so they stand until the next byte
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      reg_we_q  <= 1'b0;
      txp_we_q  <= 1'b0;
      wdata_q   <= 8'h00;
      txp_idx_q <= 5'h00;
      reg_idx_q <= 3'h0;
    end else begin
      reg_we_q <= reg_we_d & sel_on;
      txp_we_q <= txp_we_d & sel_on;
      if (reg_we_d | txp_we_d) begin
        wdata_q   <= rx_byte;
        txp_idx_q <= idx_q[4:0];
      end
      if (reg_we_d) begin
        reg_idx_q <= idx_q[2:0];
      end else if (byte_end & (state_q == ST_RD)) begin
        reg_idx_q <= idx_d[2:0];
      end else if (byte_end & (state_q == ST_CMD)) begin
        reg_idx_q <= 3'h0;
      end
    end
  end

  // ==========================================================
  // Transmit shifter: status first, then read data, else zeros
  // Output changes two to three reference cycles after the serial clock falls
  always @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sh_q     <= 8'h00;
      miso_q   <= 1'b0;
      oe_q     <= 1'b0;
      reg_rd_q <= 1'b0;
    end else begin
      oe_q     <= sel_on;
      reg_rd_q <= 1'b0;
      if (!sel_on) begin
        sh_q   <= 8'h00;
        miso_q <= 1'b0;
      end else if (sel_fall) begin
        sh_q   <= status_b;
        miso_q <= status_b[7];
      end else if (sck_fall & (bit_q == 3'h0)) begin
        // New byte boundary: fetch next register byte while in range
        if ((state_q == ST_RD) & (idx_q < REG_LIM)) begin
          sh_q     <= I_REG_RDATA;
          miso_q   <= I_REG_RDATA[7];
          reg_rd_q <= 1'b1;
        end else begin
          sh_q   <= 8'h00;
          miso_q <= 1'b0;
        end
      end else if (sck_fall) begin
        sh_q   <= {sh_q[6:0], 1'b0};
        miso_q <= sh_q[6];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign O_MISO      = miso_q;
  assign O_MISO_OE   = oe_q;
  assign O_REG_ADDR  = addr_q;
  assign O_REG_IDX   = reg_idx_q;
  assign O_REG_WE    = reg_we_q;
  assign O_REG_WDATA = wdata_q;
  assign O_REG_RD    = reg_rd_q;
  assign O_TXP_WE    = txp_we_q;
  assign O_TXP_IDX   = txp_idx_q;
  assign O_TXP_DATA  = wdata_q;

endmodule

/* File: rspi_port_properties.sv */
// Timing checker for the serial command port, bound to its top module
`timescale 1ns/1ps

module rspi_port_properties (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_ARST_N,
  input  wire logic       I_CSN_N,
  input  wire logic [7:0] I_STATUS,
  input  wire logic       O_MISO,
  input  wire logic       O_MISO_OE,
  input  wire logic       O_REG_WE,
  input  wire logic       O_TXP_WE,
  input  wire logic       O_REG_RD
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);

  // ==========================================================
  // Select edges at the pin, before the synchroniser
  sequence s_sel_fall;
    $fell(I_CSN_N);
  endsequence
  sequence s_sel_rise;
    $rose(I_CSN_N);
  endsequence

  // ==========================================================
  // Frame framing and strobes
  a_oe_on_select: assert property (s_sel_fall |-> ##[1:4] O_MISO_OE)
    else $error("drive enable late after select fall");
  a_oe_off_release: assert property (s_sel_rise |-> ##[1:4] !O_MISO_OE)
    else $error("drive enable held after select rise");
  a_status_first_bit: assert property ($rose(O_MISO_OE) |-> O_MISO == I_STATUS[7])
    else $error("first bit out is not status bit 7");
  a_reg_we_pulse: assert property (O_REG_WE |=> !O_REG_WE)
    else $error("register write strobe longer than one cycle");
  a_txp_we_pulse: assert property (O_TXP_WE |=> !O_TXP_WE)
    else $error("payload strobe longer than one cycle");
  a_rd_spacing: assert property (O_REG_RD |=> !O_REG_RD [*8])
    else $error("read strobes too close together");
  a_strobe_framed: assert property ((O_REG_WE || O_TXP_WE || O_REG_RD) |-> O_MISO_OE)
    else $error("strobe outside a selected frame");
  a_one_strobe: assert property (O_REG_WE |-> !O_TXP_WE && !O_REG_RD)
    else $error("register write mixed with another strobe");
endmodule

bind rspi_port rspi_port_properties u_props (.I_REF_CLK, .I_ARST_N, .I_CSN_N, .I_STATUS,
  .O_MISO, .O_MISO_OE, .O_REG_WE, .O_TXP_WE, .O_REG_RD);

/* File: rspi_host.sv */
// Serial master stand-in driving the command port pins
`timescale 1ns/1ps

module rspi_host (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sck = 1'b0,
  output logic      o_csn_n = 1'b1,
  output logic      o_mosi = 1'b0
);
  // ==========================================================
  // Select; data line toggles once on release so no stale bit lingers
  task sel(input logic v);
    @(posedge i_clk);
    o_csn_n <= v;
    if (v)
      o_mosi <= ~o_mosi;
    repeat (6) @(posedge i_clk);
  endtask

  // Byte shift: change on fall, sample on rise, clock idles low
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck <= 1'b0;
      o_mosi <= tx[i];
      repeat (5) @(posedge i_clk);
      o_sck <= 1'b1;
      rx[i] = i_miso;
      repeat (5) @(posedge i_clk);
    end
    // Extra low time lets read strobes land before a release
    o_sck <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the serial command port
`timescale 1ns/1ps
`include "rspi_map.vh"

module tb;
  logic       I_REF_CLK = 1'b0;
  logic       I_ARST_N = 1'b0;
  logic [7:0] I_STATUS = 8'h00;
  logic [2:0] I_PIPE_NUM = 3'h0;
  logic       I_IRQ_FALL = 1'b0;
  wire        sck, csn_n, mosi, miso, oe, reg_we, reg_rd, txp_we;
  wire  [4:0] reg_addr, txp_idx;
  wire  [2:0] reg_idx;
  wire  [7:0] wdata, txp_data, rdata;
  logic [7:0] core [0:31][0:7];
  logic [7:0] txp [0:31];
  logic [7:0] exp_stat = 8'h8f;
  logic [63:0] q;
  int         failures = 0;
  int         check_count = 0;
  int         rd_seen = 0;

  always #5 I_REF_CLK = ~I_REF_CLK;

  rspi_host h (.i_clk(I_REF_CLK), .i_miso(miso), .o_sck(sck), .o_csn_n(csn_n),
    .o_mosi(mosi));
  rspi_port i_rspi_port (.I_REF_CLK, .I_ARST_N, .I_SCK(sck), .I_CSN_N(csn_n),
    .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE(oe), .I_STATUS, .I_PIPE_NUM,
    .I_IRQ_FALL, .O_REG_ADDR(reg_addr), .O_REG_IDX(reg_idx), .O_REG_WE(reg_we),
    .O_REG_WDATA(wdata), .O_REG_RD(reg_rd), .I_REG_RDATA(rdata),
    .O_TXP_WE(txp_we), .O_TXP_IDX(txp_idx), .O_TXP_DATA(txp_data));

  // ==========================================================
  // Core stand-in, always idle so configuration writes are legal
  assign rdata = core[reg_addr][reg_idx];
  always @(posedge I_REF_CLK) begin
    if (reg_we)
      core[reg_addr][reg_idx] <= wdata;
    if (txp_we)
      txp[txp_idx] <= txp_data;
  end

  // Count of read bytes handed out by the port
  always @(posedge I_REF_CLK) begin
    if (reg_rd)
      rd_seen++;
  end

  // ==========================================================
  // Compare, verdict and one frame of n data bytes
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task finish_test;
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task frame(input logic [7:0] c, input int n, input logic [63:0] d);
    logic [7:0] b;
    q = 64'h0;
    h.sel(1'b0);
    h.xfer(c, b);
    chk(b, exp_stat);
    for (int i = 0; i < n; i++) begin
      h.xfer(d[8*i +: 8], b);
      q[8*i +: 8] = b;
    end
    h.sel(1'b1);
  endtask

  // ==========================================================
  // Scenarios
  task t_status;
    frame(`RSPI_CMD_NO_OPERATION, 1, 64'h3c);
    chk(q, 64'h0);
    I_PIPE_NUM <= 3'h2;
    I_IRQ_FALL <= 1'b1;
    @(posedge I_REF_CLK);
    I_IRQ_FALL <= 1'b0;
    exp_stat = 8'h85;
    frame(`RSPI_CMD_NO_OPERATION, 0, 64'h0);
  endtask

  task t_reg;
    frame(8'h2a, 6, 64'h66_55_44_33_22_11);
    chk(core[10][5], 8'h00);
    rd_seen = 0;
    frame(8'h0a, 6, 64'h0);
    chk(q, 64'h00_55_44_33_22_11);
    chk(rd_seen, 64'h5);
    frame(8'h2a, 2, 64'hbb_aa);
    frame(8'h0a, 5, 64'h0);
    chk(q, 64'h55_44_33_bb_aa);
    frame(8'h3f, 1, 64'h5a);
    chk(core[31][0], 8'h5a);
  endtask

  task t_txp;
    frame(`RSPI_CMD_TXP, 3, 64'h03_02_01);
    frame(`RSPI_CMD_TXP, 2, 64'hf2_f1);
    chk({txp[2], txp[1], txp[0]}, 24'h03_f2_f1);
  endtask

  task t_other;
    frame(8'he1, 2, 64'h99_98);
    chk(q, 64'h0);
    chk(core[1][0], 8'h00);
  endtask

  // ==========================================================
  // Watchdog and main sequence
  initial begin
    repeat (20000) @(posedge I_REF_CLK);
    failures++;
    finish_test;
  end

  initial begin
    foreach (core[a, b])
      core[a][b] = 8'h00;
    repeat (12) @(posedge I_REF_CLK);
    I_ARST_N <= 1'b1;
    I_STATUS <= 8'h81;
    repeat (4) @(posedge I_REF_CLK);
    t_status;
    t_reg;
    t_txp;
    t_other;
    finish_test;
  end
endmodule
